//--- xbar_window_map.svh
/*
 * Constants of the address-window router: register offsets on the APB
 * side, field positions in the target map, default-route figures.
 * Assumes it is included by bare name from the package and the router.
 */
`ifndef XBAR_WINDOW_MAP_SVH
`define XBAR_WINDOW_MAP_SVH
`define NUM_WIN 8
`define REG_W 64
`define ADDR_W 48
`define WIN_STRIDE 32
`define OFS_BASE 8'h00
`define OFS_MASK 8'h08
`define OFS_TMAP 8'h10
`define OFS_CTRL 12'h100
`define OFS_STATUS 12'h104
`define WIN_AREA_END 12'h100
`define ALIGN_BITS 10
`define TMAP_PORT_MSB 2
`define TMAP_SPEC_BIT 4
`define TMAP_BLOCK_BIT 5
`define TMAP_EN_BIT 7
`define NODE_LSB 44
`define REGION_LSB 40
`define REGION_HT0_FIRST 4'hc
`define REGION_HT1_FIRST 4'he
`define PORT_HT0 3'h6
`define PORT_HT1 3'h7
`define PORT_CFG 3'h3
`endif

//--- xbar_window_pkg.sv
/*
 * Types of the address-window router: the packed state record.
 * Assumes the constants header is on the include path.
 */
`include "xbar_window_map.svh"
package xbar_window_pkg;
   // All state of the router, registered as one word.
   typedef struct packed {
      logic [`NUM_WIN-1:0][`REG_W-1:0] base; // Window base values.
      logic [`NUM_WIN-1:0][`REG_W-1:0] mask; // Window match masks.
      logic [`NUM_WIN-1:0][`REG_W-1:0] tmap; // Window target maps.
      logic [3:0] node;                      // Local node number.
      logic [1:0] hsel;                      // Cache hash select.
      logic rsp_valid;                       // Routed request valid.
      logic rsp_hit;                         // Request hit a window.
      logic rsp_deny;                        // Request refused.
      logic [2:0] rsp_port;                  // Chosen slave port.
      logic [2:0] rsp_win;                   // Hitting window index.
      logic [`ADDR_W-1:0] rsp_addr;          // Translated address.
      logic pready;                          // APB ready.
      logic pslverr;                         // APB error.
      logic [31:0] prdata;                   // APB read data.
   } state_t;
endpackage

//--- xbar_window_router.sv
/*
 * One master port of a crossbar stage: eight prioritised address
 * windows, the fixed default route, and an APB slave for the window,
 * control and status registers.
 * Assumes one synchronous clock for bus and requests, and that
 * requests arrive one per cycle with no back-pressure.
 */
// Notes on behaviour
// - eight windows, three 64-bit registers each
// - base and mask aligned to one kilobyte
// - target map bits 2:0 pick slave port
// - target map bit 4 permits speculative access
// - target map bit 5 permits block reads
// - target map bit 7 enables the window
// - hit when address and mask equal base
// - translated address merges address and map
// - window zero highest, first hit wins
// - default route only when nothing hits
// - stage-one masters numbered 0-3, 6, 7
// - stage-one slaves: banks 0-3, links 6, 7
// - foreign node goes to link zero
// - local low space hashed over cache banks
// - upper local ranges go to links
// - stage-two misses go to port three
// - stage-two masters: banks 0, PCI 1
// - stage-two slaves: memory, low-speed, config
// - remapping never touches cache contents
`timescale 1ns/1ns
// The constants are pulled in here as well as in the package, so the
// router does not depend on the order in which files are read.
`include "xbar_window_map.svh"
module xbar_window_router
   import xbar_window_pkg::*;
#(
   parameter int STAGE = 1,       // Crossbar stage, 1 or 2.
   parameter int MASTER_ID = 0    // Master port number on the stage.
) (
   input wire logic REF_CLK,                    // Clock, 125 MHz.
   input wire logic RSTN,                       // Sync reset, low.
   input wire logic PSEL,                       // APB select.
   input wire logic PENABLE,                    // APB enable.
   input wire logic PWRITE,                     // APB direction.
   input wire logic [11:0] PADDR,               // APB byte address.
   input wire logic [31:0] PWDATA,              // APB write data.
   output logic [31:0] PRDATA,                  // APB read data.
   output logic PREADY,                         // APB ready.
   output logic PSLVERR,                        // APB error.
   input wire logic REQ_VALID,                  // Request present.
   input wire logic [`ADDR_W-1:0] REQ_ADDR,     // Request address.
   input wire logic REQ_SPEC,                   // Speculative access.
   input wire logic REQ_BLOCK,                  // Block read access.
   output logic RSP_VALID,                      // Routed request.
   output logic [2:0] RSP_PORT,                 // Slave port.
   output logic [`ADDR_W-1:0] RSP_ADDR,         // Slave address.
   output logic RSP_HIT,                        // A window hit.
   output logic [2:0] RSP_WIN,                  // Hitting window.
   output logic RSP_DENY                        // Not forwarded.
);

   state_t st_r;  // Registered state.
   state_t st_nxt; // Next state.

   logic [`NUM_WIN-1:0] hit_vec; // Enabled windows that match.
   logic [`NUM_WIN-1:0] en_vec;  // Enabled windows.
   logic [2:0] sel;              // Highest-priority hitting window.
   logic any_hit;                // At least one window hit.
   logic [`REG_W-1:0] addr_ext;  // Request address widened to 64.
   logic [`REG_W-1:0] sel_mask;  // Mask of the chosen window.
   logic [`REG_W-1:0] sel_map;   // Target map of the chosen window.
   logic [`REG_W-1:0] xlate;     // Translated address, full width.
   logic [2:0] dflt_port;        // Port from the default route.
   logic [1:0] bank;             // Cache bank from the hash bits.
   logic [31:0] rd_data;         // Read mux result.
   logic rd_ok;                  // Address maps to a register.

   assign addr_ext = {{(`REG_W-`ADDR_W){1'b0}}, REQ_ADDR};

   // Per-window compare; the enable bit gates the match itself, so a
   // window that is off cannot shadow a lower one.
   genvar g;
   generate
      for (g = 0; g < `NUM_WIN; g++) begin : g_win
         assign en_vec[g] = st_r.tmap[g][`TMAP_EN_BIT];
         assign hit_vec[g] = en_vec[g] &&
            ((addr_ext & st_r.mask[g]) == st_r.base[g]);
         // Low bits of base and mask never hold ones, whatever the
         // bus wrote, so no window can be narrower than 1KB.
         chk_base_align: assert property (
            @(posedge REF_CLK) disable iff (!RSTN)
            st_r.base[g][`ALIGN_BITS-1:0] == '0 &&
            st_r.mask[g][`ALIGN_BITS-1:0] == '0)
            else $error("Window base or mask below 1KB granularity.");
      end
   endgenerate

   // Priority pick: scanning from window 7 down lets window 0 overwrite.
   always_comb begin
      sel = 3'h0;
      for (int i = `NUM_WIN - 1; i >= 0; i--) begin
         if (hit_vec[i]) begin
            sel = 3'(i);
         end
      end
   end

   assign any_hit = |hit_vec;
   assign sel_mask = st_r.mask[sel];
   assign sel_map = st_r.tmap[sel];
   // Masked bits come from the map, the rest pass through.
   assign xlate = (addr_ext & ~sel_mask) | (sel_map & sel_mask);

   // Cache bank hash; the select moves the two interleave bits.
   always_comb begin
      case (st_r.hsel)
         2'h0: bank = REQ_ADDR[6:5];     // 0x020 steps.
         2'h1: bank = REQ_ADDR[8:7];
         2'h2: bank = REQ_ADDR[11:10];   // 0x400 steps.
         default: bank = REQ_ADDR[13:12];
      endcase
   end

   // Fixed default route, used only when no window hits.
   always_comb begin
      if (STAGE != 1) begin
         dflt_port = `PORT_CFG;
      end else if (REQ_ADDR[`NODE_LSB+3:`NODE_LSB] != st_r.node) begin
         dflt_port = `PORT_HT0;
      end else if (REQ_ADDR[`REGION_LSB+3:`REGION_LSB] <
                   `REGION_HT0_FIRST) begin
         dflt_port = {1'b0, bank};
      end else if (REQ_ADDR[`REGION_LSB+3:`REGION_LSB] <
                   `REGION_HT1_FIRST) begin
         dflt_port = `PORT_HT0;
      end else begin
         dflt_port = `PORT_HT1;
      end
   end

   // Register read mux. Window words sit at stride 32 bytes: base,
   // mask, map, each as low word then high word.
   always_comb begin
      rd_data = 32'h0;
      rd_ok = 1'b1;
      if (PADDR < `WIN_AREA_END) begin
         case (PADDR[4:3])
            2'h0: rd_data = PADDR[2] ? st_r.base[PADDR[7:5]][63:32]
                                     : st_r.base[PADDR[7:5]][31:0];
            2'h1: rd_data = PADDR[2] ? st_r.mask[PADDR[7:5]][63:32]
                                     : st_r.mask[PADDR[7:5]][31:0];
            2'h2: rd_data = PADDR[2] ? st_r.tmap[PADDR[7:5]][63:32]
                                     : st_r.tmap[PADDR[7:5]][31:0];
            default: rd_ok = 1'b0;
         endcase
         if (PADDR[1:0] != 2'h0) begin
            rd_ok = 1'b0;
         end
      end else if (PADDR == `OFS_CTRL) begin
         rd_data = {26'h0, st_r.hsel, st_r.node};
      end else if (PADDR == `OFS_STATUS) begin
         // Shows the last routing decision.
         rd_data = {24'h0, st_r.rsp_deny, st_r.rsp_hit, st_r.rsp_win,
                    st_r.rsp_port};
      end else begin
         rd_ok = 1'b0;
      end
   end

   // Next-state logic: APB slave and request routing.
   always_comb begin
      st_nxt = st_r;
      // The access phase takes two cycles: the first edge latches the
      // answer and raises ready, the second completes the transfer.
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      if (PSEL && PENABLE && !st_r.pready) begin
         st_nxt.pready = 1'b1;
         st_nxt.pslverr = !rd_ok;
         st_nxt.prdata = PWRITE ? 32'h0 : (rd_ok ? rd_data : 32'h0);
      end
      // Writes land on the completing edge only, so a request sampled
      // in the same cycle still sees the old windows.
      if (PSEL && PENABLE && st_r.pready && PWRITE && !st_r.pslverr) begin
         if (PADDR < `WIN_AREA_END) begin
            case (PADDR[4:3])
               2'h0: begin
                  if (PADDR[2]) begin
                     st_nxt.base[PADDR[7:5]][63:32] = PWDATA;
                  end else begin
                     // Low bits held at zero keep windows 1KB aligned.
                     st_nxt.base[PADDR[7:5]][31:0] =
                        {PWDATA[31:`ALIGN_BITS], 10'h0};
                  end
               end
               2'h1: begin
                  if (PADDR[2]) begin
                     st_nxt.mask[PADDR[7:5]][63:32] = PWDATA;
                  end else begin
                     st_nxt.mask[PADDR[7:5]][31:0] =
                        {PWDATA[31:`ALIGN_BITS], 10'h0};
                  end
               end
               default: begin
                  if (PADDR[2]) begin
                     st_nxt.tmap[PADDR[7:5]][63:32] = PWDATA;
                  end else begin
                     st_nxt.tmap[PADDR[7:5]][31:0] = PWDATA;
                  end
               end
            endcase
         end else if (PADDR == `OFS_CTRL) begin
            // Only the control word is writable outside the windows;
            // the status word quietly ignores writes.
            st_nxt.node = PWDATA[3:0];
            st_nxt.hsel = PWDATA[5:4];
         end
      end
      // Routing: one registered cycle from request to answer. Nothing
      // here reaches the caches, so a remap leaves stale lines alone.
      st_nxt.rsp_valid = REQ_VALID;
      if (REQ_VALID) begin
         st_nxt.rsp_hit = any_hit;
         st_nxt.rsp_win = any_hit ? sel : 3'h0;
         if (any_hit) begin
            st_nxt.rsp_port = sel_map[`TMAP_PORT_MSB:0];
            st_nxt.rsp_addr = xlate[`ADDR_W-1:0];
            st_nxt.rsp_deny =
               (REQ_SPEC && !sel_map[`TMAP_SPEC_BIT]) ||
               (REQ_BLOCK && !sel_map[`TMAP_BLOCK_BIT]);
         end else begin
            st_nxt.rsp_port = dflt_port;
            st_nxt.rsp_addr = REQ_ADDR;
            st_nxt.rsp_deny = 1'b0;
         end
      end
   end

   // State register; reset leaves every window disabled, so all
   // traffic takes the default route until software configures one.
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign PRDATA = st_r.prdata;
   assign PREADY = st_r.pready;
   assign PSLVERR = st_r.pslverr;
   assign RSP_VALID = st_r.rsp_valid;
   assign RSP_PORT = st_r.rsp_port;
   assign RSP_ADDR = st_r.rsp_addr;
   assign RSP_HIT = st_r.rsp_hit;
   assign RSP_WIN = st_r.rsp_win;
   assign RSP_DENY = st_r.rsp_deny;

   // Checks on the routing and bus answers.
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);

   chk_port_from_map: assert property (
      REQ_VALID && any_hit |=> RSP_PORT == $past(sel_map[2:0]))
      else $error("Hit port differs from target map.");

   chk_xlate_addr: assert property (
      REQ_VALID && any_hit |=> RSP_ADDR ==
         $past((REQ_ADDR & ~sel_mask[`ADDR_W-1:0]) |
               (sel_map[`ADDR_W-1:0] & sel_mask[`ADDR_W-1:0])))
      else $error("Translated address is wrong.");

   chk_unconfig_default: assert property (
      REQ_VALID && en_vec == '0 |=> RSP_VALID && !RSP_HIT)
      else $error("Hit reported with every window off.");

   chk_win0_first: assert property (
      REQ_VALID && hit_vec[0] |=> RSP_HIT && RSP_WIN == 3'h0)
      else $error("Window zero did not take priority.");

   chk_spec_deny: assert property (
      REQ_VALID && REQ_SPEC && any_hit && !sel_map[`TMAP_SPEC_BIT]
      |=> RSP_DENY)
      else $error("Speculative access forwarded without permission.");

   chk_block_deny: assert property (
      REQ_VALID && !REQ_SPEC && REQ_BLOCK && any_hit &&
      sel_map[`TMAP_BLOCK_BIT] |=> !RSP_DENY)
      else $error("Permitted block read was refused.");

   chk_remote_node: assert property (
      STAGE == 1 && REQ_VALID && !any_hit &&
      REQ_ADDR[`NODE_LSB+3:`NODE_LSB] != st_r.node
      |=> RSP_PORT == `PORT_HT0)
      else $error("Foreign node not sent to link zero.");

   chk_ht1_range: assert property (
      STAGE == 1 && REQ_VALID && !any_hit &&
      REQ_ADDR[`NODE_LSB+3:`NODE_LSB] == st_r.node &&
      REQ_ADDR[`REGION_LSB+3:`REGION_LSB] >= `REGION_HT1_FIRST
      |=> RSP_PORT == `PORT_HT1)
      else $error("Upper local range not sent to link one.");

   chk_stage2_miss: assert property (
      STAGE == 2 && REQ_VALID && !any_hit |=> RSP_PORT == `PORT_CFG)
      else $error("Stage-two miss not sent to port three.");

   chk_apb_answer: assert property (
      PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
      else $error("APB ready not a single pulse after one wait.");

   // An error answer is only meaningful together with ready.
   chk_err_with_ready: assert property (
      PSLVERR |-> PREADY)
      else $error("Bus error shown without ready.");

   // Configuration checks: a master number outside its stage's list
   // means the router was placed on a port that the stage lacks.
   // They cost nothing in hardware and catch a wrong instance early.
   chk_master_num: assert property (
      STAGE != 1 || MASTER_ID inside {0, 1, 2, 3, 6, 7})
      else $error("Stage-one master number not allowed.");

   chk_stage2_master: assert property (
      STAGE != 2 || MASTER_ID inside {0, 1})
      else $error("Stage-two master number not allowed.");

   // A miss keeps its address untouched and is never refused.
   chk_miss_plain: assert property (
      REQ_VALID && !any_hit |=> RSP_VALID && !RSP_HIT && !RSP_DENY &&
         RSP_ADDR == $past(REQ_ADDR))
      else $error("Missed request was altered.");

   // A hit may only come from a window whose enable bit is set.
   chk_hit_enabled: assert property (
      REQ_VALID && any_hit |=> RSP_HIT &&
         $past(st_r.tmap[sel][`TMAP_EN_BIT]))
      else $error("A disabled window took the request.");

   // Local low space: the bank follows the hash bits of the address.
   // Written out for select values 0 and 2 rather than through the bank mux,
   // so a slip in the mux does not hide itself.
   chk_hash_sel0: assert property (
      STAGE == 1 && REQ_VALID && !any_hit && st_r.hsel == 2'h0 &&
      REQ_ADDR[`NODE_LSB+3:`NODE_LSB] == st_r.node &&
      REQ_ADDR[`REGION_LSB+3:`REGION_LSB] < `REGION_HT0_FIRST
      |=> RSP_PORT == {1'b0, $past(REQ_ADDR[6:5])})
      else $error("Bank pick on small steps is wrong.");

   chk_hash_sel2: assert property (
      STAGE == 1 && REQ_VALID && !any_hit && st_r.hsel == 2'h2 &&
      REQ_ADDR[`NODE_LSB+3:`NODE_LSB] == st_r.node &&
      REQ_ADDR[`REGION_LSB+3:`REGION_LSB] < `REGION_HT0_FIRST
      |=> RSP_PORT == {1'b0, $past(REQ_ADDR[11:10])})
      else $error("Bank pick on kilobyte steps is wrong.");

   // The middle local range belongs to link zero.
   chk_ht0_range: assert property (
      STAGE == 1 && REQ_VALID && !any_hit &&
      REQ_ADDR[`NODE_LSB+3:`NODE_LSB] == st_r.node &&
      REQ_ADDR[`REGION_LSB+3:`REGION_LSB] >= `REGION_HT0_FIRST &&
      REQ_ADDR[`REGION_LSB+3:`REGION_LSB] < `REGION_HT1_FIRST
      |=> RSP_PORT == `PORT_HT0)
      else $error("Middle local range not sent to link zero.");

   cov_window_hit: cover property (REQ_VALID && any_hit ##1 RSP_HIT);
   cov_default_route: cover property (REQ_VALID && !any_hit);
   cov_denied: cover property (RSP_VALID && RSP_DENY);
   cov_apb_write: cover property (PSEL && PENABLE && PREADY && PWRITE);
   cov_apb_error: cover property (PREADY && PSLVERR);

endmodule // xbar_window_router

//--- xbar_port_sink.sv
/*
 * Far-side model of one router: a slave-port sink that counts the
 * requests each slave port would receive.
 * Assumes the router's response outputs and its clock.
 */
`timescale 1ns/1ns
module xbar_port_sink (
   input wire logic clk,        // Router clock.
   input wire logic valid,      // Routed request present.
   input wire logic [2:0] port, // Chosen slave port.
   input wire logic deny        // Request must not go out.
);
   int unsigned taken [8] = '{default: 0}; // Requests per slave port.
   // A refused request never reaches a slave, so it is not counted.
   always @(posedge clk) begin
      if (valid === 1'b1 && deny === 1'b0) begin
         taken[port] <= taken[port] + 1;
      end
   end
endmodule // xbar_port_sink

//--- crossbar_address_window_router_bench.sv
/*
 * Self-checking bench: a stage-one and a stage-two router side by side,
 * an APB master, random and corner-case requests.
 * Assumes the router package and header, and the port sink model.
 */
`timescale 1ns/1ns
module crossbar_address_window_router_bench;
   import xbar_window_pkg::*;
   logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0; // Bus strobes.
   logic [11:0] pa = '0; // APB address.
   logic [31:0] pwd = '0; // APB write data.
   logic [1:0] tgt = 2'h3; // Routers that take the APB transfer.
   logic rv = 0, rsp = 0, rbk = 0; // Request strobe and kind.
   logic [47:0] ra = '0; // Request address.
   logic [31:0] prd [2];
   logic rdy [2], err [2], ov [2], oh [2], od [2];
   logic [2:0] op [2], ow [2];
   logic [47:0] oa [2];
   logic [63:0] sb [2][8], sm [2][8], st [2][8]; // Window shadows.
   logic [3:0] node = '0; // Local node number in use.
   logic [1:0] hsel = '0; // Cache hash select in use.
   logic [47:0] edge_a [5] = '{48'hfbff_ffff_ffff, 48'hfc00_0000_0000,
      48'hfdff_ffff_ffff, 48'hfe00_0000_0000, 48'h0e00_0000_0000};
   int fails = 0, check_count = 0, fwd = 0;

   for (genvar g = 0; g < 2; g++) begin : rt
      xbar_window_router #(.STAGE(g + 1), .MASTER_ID(0)) dut_u (
         .REF_CLK(clk), .RSTN(rstn), .PSEL(psel & tgt[g]),
         .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
         .PRDATA(prd[g]), .PREADY(rdy[g]), .PSLVERR(err[g]),
         .REQ_VALID(rv), .REQ_ADDR(ra), .REQ_SPEC(rsp), .REQ_BLOCK(rbk),
         .RSP_VALID(ov[g]), .RSP_PORT(op[g]), .RSP_ADDR(oa[g]),
         .RSP_HIT(oh[g]), .RSP_WIN(ow[g]), .RSP_DENY(od[g]));
      xbar_port_sink sink_u (.clk(clk), .valid(ov[g]), .port(op[g]),
         .deny(od[g]));
   end

   // The 125 MHz clock.
   initial begin
      forever #4 clk = ~clk;
   end

   // Counts a comparison and reports a difference at once.
   task automatic chk(logic [63:0] got, logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic wrap_up();
      if (fails == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One APB transfer; it waits for ready as long as it takes and
   // leaves a hang to the watchdog.
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
         output logic [31:0] q, output logic e);
      int i;
      @(posedge clk);
      i = tgt[0] ? 0 : 1;
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (rdy[i] !== 1'b1);
      q = prd[i];
      e = err[i];
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // A 64-bit register is two independent words, low half first.
   task automatic wr64(logic [11:0] a, logic [63:0] v);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, v[31:0], q, e);
      apb(1'b1, a + 12'h4, v[63:32], q, e);
   endtask

   // Programs one window of one stage and updates the shadow after it.
   task automatic win(int s, int w, logic [63:0] b, m, t);
      tgt <= s ? 2'h2 : 2'h1;
      wr64(12'(w * 32), b);
      wr64(12'(w * 32 + 8), m);
      wr64(12'(w * 32 + 16), t);
      sb[s][w] = {b[63:10], 10'h0};
      sm[s][w] = {m[63:10], 10'h0};
      st[s][w] = t;
   endtask

   // Sets node number and hash select on both routers.
   task automatic ctl(logic [3:0] n, logic [1:0] h);
      logic [31:0] q;
      logic e;
      tgt <= 2'h3;
      apb(1'b1, 12'h100, {26'h0, h, n}, q, e);
      node = n;
      hsel = h;
   endtask

   // Expected {hit, window, deny, port, address} of one stage.
   function automatic logic [55:0] route(int s, logic [47:0] a,
         logic sp, logic bk);
      logic [63:0] x;
      logic [63:0] m;
      logic [63:0] t;
      logic [63:0] y;
      logic [2:0] p;
      x = {16'h0, a};
      for (int w = 0; w < 8; w++) begin
         m = sm[s][w];
         t = st[s][w];
         y = (x & ~m) | (t & m);
         if (t[7] && (x & m) == sb[s][w]) begin
            return {1'b1, 3'(w), (sp && !t[4]) || (bk && !t[5]), t[2:0],
               y[47:0]};
         end
      end
      if (s == 1) return {5'h0, 3'h3, a};
      if (a[47:44] != node) return {5'h0, 3'h6, a};
      if (a[43:40] >= 4'hc) return {5'h0, a[41] ? 3'h7 : 3'h6, a};
      case (hsel)
         2'h0: p = {1'b0, a[6:5]};
         2'h1: p = {1'b0, a[8:7]};
         2'h2: p = {1'b0, a[11:10]};
         default: p = {1'b0, a[13:12]};
      endcase
      return {5'h0, p, a};
   endfunction

   // One request to both routers; results stand one cycle later.
   task automatic req(logic [47:0] a, logic sp, logic bk);
      logic [55:0] e [2];
      e[0] = route(0, a, sp, bk);
      e[1] = route(1, a, sp, bk);
      @(posedge clk);
      rv <= 1'b1;
      ra <= a;
      rsp <= sp;
      rbk <= bk;
      @(posedge clk);
      rv <= 1'b0;
      @(posedge clk);
      for (int g = 0; g < 2; g++) begin
         chk({ov[g], oh[g], ow[g], od[g], op[g], oa[g]}, {1'b1, e[g]});
         if (!e[g][51]) fwd++;
      end
   endtask

   // Random addresses inside base | mask, random access kinds.
   task automatic burst(logic [47:0] base, logic [47:0] msk, int n);
      for (int i = 0; i < n; i++) begin
         req(base | (48'({$urandom, $urandom}) & msk), 1'($urandom),
            1'($urandom));
      end
   endtask

   // A hang is cut short well after the expected run of under a thousand cycles.
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      wrap_up();
   end

   initial begin
      logic [31:0] q;
      logic e;
      int sum;
      void'($urandom(63));
      foreach (sb[s, w]) begin
         sb[s][w] = '0;
         sm[s][w] = '0;
         st[s][w] = '0;
      end
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      // Nothing configured yet, so every request takes the default route.
      burst(48'h0, 48'hffff_ffff_ffff, 30);
      burst(48'h0, 48'h0fff_ffff_ffff, 30);
      for (int h = 0; h < 4; h++) begin
         ctl(4'(h * 5), 2'(h));
         burst({4'(h * 5), 44'h0}, 48'h0bff_ffff_ffff, 12);
      end
      foreach (edge_a[i]) req(edge_a[i], 1'b0, 1'b0);
      tgt <= 2'h1;
      apb(1'b0, 12'h108, 32'h0, q, e);
      chk({e, q}, {1'b1, 32'h0});
      apb(1'b0, 12'h018, 32'h0, q, e);
      chk({e, q}, {1'b1, 32'h0});
      apb(1'b0, 12'h100, 32'h0, q, e);
      chk({e, q}, {1'b0, 26'h0, hsel, node});
      // Stage one: window 0 sits inside window 3 and must win.
      ctl(4'h0, 2'h0);
      win(0, 0, 64'h1800_0000, 64'hffff_ffff_fc00_0000,
         64'h0efd_fc00_00f7);
      win(0, 3, 64'h1000_03ff, 64'hffff_ffff_f000_0000,
         64'h1000_00f1);
      apb(1'b0, 12'h060, 32'h0, q, e);
      chk({e, q}, {1'b0, 32'h1000_0000});
      burst(48'h1000_0000, 48'h0fff_ffff, 30);
      // A disabled window must give way to the lower one.
      win(0, 0, 64'h1800_0000, 64'hffff_ffff_fc00_0000,
         64'h0efd_fc00_0077);
      burst(48'h1800_0000, 48'h03ff_ffff, 12);
      // Stage two: guarded low-speed space refuses speculation.
      win(1, 0, 64'h1000_0000, 64'hffff_ffff_f000_0000,
         64'h1000_0082);
      win(1, 1, 64'h2fc0_0000, 64'hffff_ffff_fff0_0000,
         64'h1fc0_00f2);
      for (int k = 0; k < 4; k++) begin
         req(48'h1234_5600, 1'(k), 1'(k >> 1));
         req(48'h2fc1_2300, 1'(k), 1'(k >> 1));
      end
      burst(48'h0, 48'h3fff_ffff, 30);
      // A mid-run reset must drop every window and the control word.
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      foreach (st[s, w]) st[s][w] = '0;
      node = '0;
      hsel = '0;
      apb(1'b0, 12'h100, 32'h0, q, e);
      chk({e, q}, {1'b0, 32'h0});
      burst(48'h0, 48'h3fff_ffff, 8);
      @(posedge clk);
      sum = 0;
      for (int p = 0; p < 8; p++) begin
         sum += rt[0].sink_u.taken[p] + rt[1].sink_u.taken[p];
      end
      chk(64'(sum), 64'(fwd));
      wrap_up();
   end
endmodule // crossbar_address_window_router_bench
